//--- design/btw_cfg.svh
`ifndef BTW_CFG_SVH
`define BTW_CFG_SVH

// register byte offsets
`define BTW_ADDR_W      8
`define BTW_GPT_CTRL    8'h00
`define BTW_GPT_BASE0   8'h10
`define BTW_GPT_CNT0    8'h20
`define BTW_WD1_CTL     8'h30
`define BTW_WD2_CTL     8'h34
`define BTW_WD1_CNT     8'h38
`define BTW_WD2_CNT     8'h3c
`define BTW_STATUS      8'h40
`define BTW_MASK        8'h44

// field layouts
`define BTW_NUM_GPT     4
`define BTW_GPT_W       32
`define BTW_CTRL_W      12
`define BTW_CTRL_WMASK  12'hf0f
`define BTW_GPT_IE_LSB  8
`define BTW_ST_W        6
`define BTW_ST_WD1_BIT  4
`define BTW_ST_WD2_BIT  5
`define BTW_WD_W        22
`define BTW_WD_KEY_MSB  31
`define BTW_WD_KEY_LSB  24
`define BTW_WD_EN_BIT   23
`define BTW_WD_RLD_BIT  22
`define BTW_KEY_ARM     8'h55
`define BTW_KEY_UPD     8'haa

// timing
`define BTW_CLK_NS      8
`define BTW_US_NS       1000
`define BTW_US_CYC      ((`BTW_US_NS) / (`BTW_CLK_NS))
`define BTW_GPT_DIV     8
`define BTW_WD_MIN_US   1
`define BTW_WD_MAX_US   4000000
`define BTW_WD1_DEF_MS  512
`define BTW_WD2_DEF_MS  576

`endif

//--- design/btw_gpt.sv
`timescale 1ns/1ps
`default_nettype none
`include "btw_cfg.svh"

module btw_gpt import btw_pkg::*; (
	// clock and reset
	input  wire logic     clk,
	input  wire logic     rstn,
	// control
	input  wire logic     tick,
	input  wire logic     en,
	input  wire logic     load,
	input  wire btw_gpt_t load_val,
	// state
	output btw_gpt_t      base,
	output btw_gpt_t      count,
	output logic          evt
);
	btw_gpt_t base_reg, base_next, cnt_reg, cnt_next;
	logic     evt_reg, evt_next;

	always_comb begin
		base_next = base_reg;
		cnt_next  = cnt_reg;
		evt_next  = 1'b0;
		if (load) begin
			base_next = load_val;
			cnt_next  = load_val;
		end else if (tick && en) begin
			if (cnt_reg == '0) begin
				cnt_next = base_reg;
				evt_next = 1'b1;
			end else begin
				cnt_next = cnt_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			base_reg <= '0;
			cnt_reg  <= '0;
			evt_reg  <= 1'b0;
		end else begin
			base_reg <= base_next;
			cnt_reg  <= cnt_next;
			evt_reg  <= evt_next;
		end
	end

	assign base  = base_reg;
	assign count = cnt_reg;
	assign evt   = evt_reg;

	gpt_wrap_a: assert property (
		@(posedge clk) disable iff (!rstn)
		(!load && tick && en && cnt_reg == '0) |=> (evt_reg && cnt_reg == $past(base_reg)))
		else $error("timer did not reload from base at zero");
endmodule

`default_nettype wire

//--- design/btw_pkg.sv
`include "btw_cfg.svh"

package btw_pkg;
	typedef logic [`BTW_WD_W-1:0]  btw_wdcnt_t;
	typedef logic [`BTW_GPT_W-1:0] btw_gpt_t;
	typedef enum logic [0:0] {
		BTW_KEY_IDLE  = 1'b0,
		BTW_KEY_ARMED = 1'b1
	} btw_key_e;
endpackage

//--- design/btw_top.sv
// Functional notes
// - four general purpose timers, each with a 32-bit count.
// - the timers advance on a divide-by-eight prescaler synchronous to the bus clock.
// - each timer can be enabled to raise an interrupt request.
// - two watchdogs of identical function, fully independent of each other.
// - an enabled watchdog counts down until zero or until software reloads it.
// - the watchdog period is programmable from 1 microsecond to 4 seconds.
// - a watchdog whose count reaches zero asserts its timeout output.
// - the first watchdog's timeout becomes an interrupt request.
// - the second watchdog's timeout is ORed with other reset sources into a hard reset.
// - after reset both watchdogs run, with 512 ms and 576 ms default periods.
// - an update either loads a new period or reloads the previously loaded one.
// - a write of 0x55 to the key field arms the watchdog for one update.
// - a following write of 0xaa with new settings applies them.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "btw_cfg.svh"

module btw_top import btw_pkg::*; #(
	parameter btw_wdcnt_t WD1_DEFAULT_US = btw_wdcnt_t'(`BTW_WD1_DEF_MS * 1000),
	parameter btw_wdcnt_t WD2_DEFAULT_US = btw_wdcnt_t'(`BTW_WD2_DEF_MS * 1000)
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RSTN,
	// ahb-lite slave
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// board reset and interrupt lines
	input  wire logic        BRD_RST_SRC,
	output logic             IRQ,
	output logic             INT_WDOG_REQ,
	output logic             RST_WDOG_OUT,
	output logic             HARD_RESET
);
	localparam int NG = `BTW_NUM_GPT;

	// bus phase tracking
	logic                   addr_ph;
	logic                   wr_pend_reg, wr_pend_next;
	logic [`BTW_ADDR_W-1:0] waddr_reg, waddr_next;
	logic [31:0]            rdata_reg, rdata_next;

	// prescalers
	logic [2:0]             pre8_reg, pre8_next;
	logic [6:0]             preus_reg, preus_next;
	logic                   gpt_tick_reg, gpt_tick_next;
	logic                   us_tick_reg, us_tick_next;

	// software registers and status
	logic [`BTW_CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [`BTW_ST_W-1:0]   status_reg, status_next;
	logic [`BTW_ST_W-1:0]   mask_reg, mask_next;
	logic [`BTW_ST_W-1:0]   w1c, events;
	logic                   iwd_to_d_reg, rwd_to_d_reg;

	// pins and outputs
	logic                   brd_s1_reg, brd_s2_reg;
	logic                   irq_reg, irq_next;
	logic                   iwreq_reg, rwout_reg, hrst_reg, hrst_next;

	btw_gpt_t               gpt_base [NG];
	btw_gpt_t               gpt_cnt  [NG];
	logic [NG-1:0]          gpt_ld, gpt_evt;

	btw_wd_if interrupt_watchdog_bus ();
	btw_wd_if reset_watchdog_bus ();

	function automatic logic [31:0] rd_mux(input logic [`BTW_ADDR_W-1:0] a);
		logic [31:0] v;
		v = '0;
		case (a)
			`BTW_GPT_CTRL: v = 32'(ctrl_reg);
			`BTW_WD1_CTL: v = {8'h00, interrupt_watchdog_bus.en, interrupt_watchdog_bus.timeout,
				interrupt_watchdog_bus.load_val};
			`BTW_WD2_CTL: v = {8'h00, reset_watchdog_bus.en, reset_watchdog_bus.timeout,
				reset_watchdog_bus.load_val};
			`BTW_WD1_CNT: v = 32'(interrupt_watchdog_bus.count);
			`BTW_WD2_CNT: v = 32'(reset_watchdog_bus.count);
			`BTW_STATUS: v = 32'(status_reg);
			`BTW_MASK: v = 32'(mask_reg);
			default: v = '0;
		endcase
		for (int i = 0; i < NG; i++) begin
			if (a == `BTW_ADDR_W'(`BTW_GPT_BASE0 + 4 * i)) v = gpt_base[i];
			if (a == `BTW_ADDR_W'(`BTW_GPT_CNT0 + 4 * i)) v = gpt_cnt[i];
		end
		return v;
	endfunction

	// only whole-word transfers are honoured; others complete okay but do nothing
	assign addr_ph = HSEL && HREADY && HTRANS[1] && HSIZE == 3'b010;

	always_comb begin
		wr_pend_next = addr_ph && HWRITE;
		waddr_next   = addr_ph ? HADDR[`BTW_ADDR_W-1:0] : waddr_reg;
		rdata_next   = (addr_ph && !HWRITE) ? rd_mux(HADDR[`BTW_ADDR_W-1:0]) : '0;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			wr_pend_reg <= 1'b0;
			waddr_reg   <= '0;
			rdata_reg   <= '0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			waddr_reg   <= waddr_next;
			rdata_reg   <= rdata_next;
		end
	end

	// one shared divider keeps all four timers in step with each other
	always_comb begin
		pre8_next     = (pre8_reg == 3'(`BTW_GPT_DIV - 1)) ? '0 : pre8_reg + 3'd1;
		gpt_tick_next = (pre8_reg == 3'(`BTW_GPT_DIV - 1));
		preus_next    = (preus_reg == 7'(`BTW_US_CYC - 1)) ? '0 : preus_reg + 7'd1;
		us_tick_next  = (preus_reg == 7'(`BTW_US_CYC - 1));
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pre8_reg     <= '0;
			preus_reg    <= '0;
			gpt_tick_reg <= 1'b0;
			us_tick_reg  <= 1'b0;
		end else begin
			pre8_reg     <= pre8_next;
			preus_reg    <= preus_next;
			gpt_tick_reg <= gpt_tick_next;
			us_tick_reg  <= us_tick_next;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NG; g++) begin : gen_gpt
			assign gpt_ld[g] = wr_pend_reg && waddr_reg == `BTW_ADDR_W'(`BTW_GPT_BASE0 + 4 * g);
			btw_gpt u_gpt (
				.clk      (CLK),
				.rstn     (RSTN),
				.tick     (gpt_tick_reg),
				.en       (ctrl_reg[g]),
				.load     (gpt_ld[g]),
				.load_val (HWDATA),
				.base     (gpt_base[g]),
				.count    (gpt_cnt[g]),
				.evt      (gpt_evt[g])
			);
		end
	endgenerate

	// two separate instances with separate buses share no state
	assign interrupt_watchdog_bus.wr    = wr_pend_reg && waddr_reg == `BTW_WD1_CTL;
	assign interrupt_watchdog_bus.wdata = HWDATA;
	assign reset_watchdog_bus.wr        = wr_pend_reg && waddr_reg == `BTW_WD2_CTL;
	assign reset_watchdog_bus.wdata     = HWDATA;

	btw_wdog #(.DEF_US(WD1_DEFAULT_US)) u_interrupt_watchdog (
		.clk  (CLK),
		.rstn (RSTN),
		.tick (us_tick_reg),
		.bus  (interrupt_watchdog_bus)
	);

	btw_wdog #(.DEF_US(WD2_DEFAULT_US)) u_reset_watchdog (
		.clk  (CLK),
		.rstn (RSTN),
		.tick (us_tick_reg),
		.bus  (reset_watchdog_bus)
	);

	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		w1c       = '0;
		if (wr_pend_reg) begin
			case (waddr_reg)
				`BTW_GPT_CTRL: ctrl_next = HWDATA[`BTW_CTRL_W-1:0] & `BTW_CTRL_WMASK;
				`BTW_MASK: mask_next = HWDATA[`BTW_ST_W-1:0];
				`BTW_STATUS: w1c = HWDATA[`BTW_ST_W-1:0];
				default: ctrl_next = ctrl_reg;
			endcase
		end
		events = '0;
		events[NG-1:0] = gpt_evt & ctrl_reg[`BTW_GPT_IE_LSB +: NG];
		events[`BTW_ST_WD1_BIT] = interrupt_watchdog_bus.timeout && !iwd_to_d_reg;
		events[`BTW_ST_WD2_BIT] = reset_watchdog_bus.timeout && !rwd_to_d_reg;
		// a new event beats a clear landing in the same cycle
		status_next = (status_reg & ~w1c) | events;
		irq_next    = |(status_next & mask_next);
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_reg     <= '0;
			mask_reg     <= '0;
			status_reg   <= '0;
			irq_reg      <= 1'b0;
			iwd_to_d_reg <= 1'b0;
			rwd_to_d_reg <= 1'b0;
		end else begin
			ctrl_reg     <= ctrl_next;
			mask_reg     <= mask_next;
			status_reg   <= status_next;
			irq_reg      <= irq_next;
			iwd_to_d_reg <= interrupt_watchdog_bus.timeout;
			rwd_to_d_reg <= reset_watchdog_bus.timeout;
		end
	end

	// board reset sources arrive asynchronously; the hard reset is held off
	// externally for seconds, so three cycles of latency here cost nothing
	always_comb begin
		hrst_next = brd_s2_reg || reset_watchdog_bus.timeout;
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			brd_s1_reg <= 1'b0;
			brd_s2_reg <= 1'b0;
			hrst_reg   <= 1'b0;
			iwreq_reg  <= 1'b0;
			rwout_reg  <= 1'b0;
		end else begin
			brd_s1_reg <= BRD_RST_SRC;
			brd_s2_reg <= brd_s1_reg;
			hrst_reg   <= hrst_next;
			iwreq_reg  <= interrupt_watchdog_bus.timeout;
			rwout_reg  <= reset_watchdog_bus.timeout;
		end
	end

	assign HRDATA       = rdata_reg;
	assign HREADYOUT    = 1'b1;
	assign HRESP        = 1'b0;
	assign IRQ          = irq_reg;
	assign INT_WDOG_REQ = iwreq_reg;
	assign RST_WDOG_OUT = rwout_reg;
	assign HARD_RESET   = hrst_reg;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	gpt_tick_space_a: assert property (
		gpt_tick_reg |=> !gpt_tick_reg [*7] ##1 gpt_tick_reg)
		else $error("timer prescaler period is not eight");
	gpt_irq_a: assert property (
		(gpt_evt[0] && ctrl_reg[`BTW_GPT_IE_LSB]) |=> status_reg[0] ##1 (irq_reg == mask_reg[0]
			|| !status_reg[0] || $past(|(status_reg & mask_reg))))
		else $error("enabled timer event not recorded");
	wd1_request_a: assert property (
		$rose(interrupt_watchdog_bus.timeout) |=> INT_WDOG_REQ && status_reg[`BTW_ST_WD1_BIT])
		else $error("first watchdog timeout not requested");
	hard_reset_a: assert property (
		(reset_watchdog_bus.timeout || brd_s2_reg) |=> HARD_RESET)
		else $error("hard reset not asserted");
	no_spurious_reset_a: assert property (
		(!reset_watchdog_bus.timeout && !brd_s2_reg) |=> !HARD_RESET)
		else $error("hard reset without source");
	wd_default_run_a: assert property (
		$rose(RSTN) |-> interrupt_watchdog_bus.en && reset_watchdog_bus.en
			&& interrupt_watchdog_bus.load_val == WD1_DEFAULT_US
			&& reset_watchdog_bus.load_val == WD2_DEFAULT_US)
		else $error("watchdog defaults wrong after reset");
	status_set_wins_a: assert property (
		(wr_pend_reg && waddr_reg == `BTW_STATUS && events[`BTW_ST_WD1_BIT])
			|=> status_reg[`BTW_ST_WD1_BIT])
		else $error("event lost against clear");
	irq_level_a: assert property (
		##1 irq_reg == |(status_reg & mask_reg))
		else $error("interrupt output disagrees with status");
endmodule

`default_nettype wire

//--- design/btw_wd_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "btw_cfg.svh"

interface btw_wd_if import btw_pkg::*;;
	logic        wr;
	logic [31:0] wdata;
	logic        en;
	logic        timeout;
	btw_wdcnt_t  load_val;
	btw_wdcnt_t  count;
	modport ctl (output wr, wdata, input en, timeout, load_val, count);
	modport wd  (input wr, wdata, output en, timeout, load_val, count);
endinterface

`default_nettype wire

//--- design/btw_wdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "btw_cfg.svh"

module btw_wdog import btw_pkg::*; #(
	parameter btw_wdcnt_t DEF_US = btw_wdcnt_t'(`BTW_WD1_DEF_MS * 1000)
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick,
	btw_wd_if.wd     bus
);
	btw_key_e   key_reg, key_next;
	logic       en_reg, en_next, to_reg, to_next;
	btw_wdcnt_t load_reg, load_next, cnt_reg, cnt_next, req_val;
	logic [7:0] key;

	always_comb begin
		key     = bus.wdata[`BTW_WD_KEY_MSB:`BTW_WD_KEY_LSB];
		req_val = bus.wdata[`BTW_WD_W-1:0];
		// out-of-range requests are pinned to the nearest legal period
		if (req_val < btw_wdcnt_t'(`BTW_WD_MIN_US)) req_val = btw_wdcnt_t'(`BTW_WD_MIN_US);
		if (req_val > btw_wdcnt_t'(`BTW_WD_MAX_US)) req_val = btw_wdcnt_t'(`BTW_WD_MAX_US);
		key_next  = key_reg;
		en_next   = en_reg;
		to_next   = to_reg;
		load_next = load_reg;
		cnt_next  = cnt_reg;
		if (tick && en_reg && cnt_reg != '0) begin
			cnt_next = cnt_reg - 1'b1;
			if (cnt_reg == btw_wdcnt_t'(1)) to_next = 1'b1;
		end
		// an update wins over a tick in the same cycle
		if (bus.wr) begin
			case (key_reg)
				BTW_KEY_IDLE: begin
					key_next = (key == `BTW_KEY_ARM) ? BTW_KEY_ARMED : BTW_KEY_IDLE;
				end
				BTW_KEY_ARMED: begin
					key_next = BTW_KEY_IDLE;
					if (key == `BTW_KEY_UPD) begin
						en_next = bus.wdata[`BTW_WD_EN_BIT];
						to_next = 1'b0;
						if (bus.wdata[`BTW_WD_RLD_BIT]) begin
							cnt_next = load_reg;
						end else begin
							load_next = req_val;
							cnt_next  = req_val;
						end
					end
				end
				default: key_next = BTW_KEY_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			key_reg  <= BTW_KEY_IDLE;
			en_reg   <= 1'b1;
			to_reg   <= 1'b0;
			load_reg <= DEF_US;
			cnt_reg  <= DEF_US;
		end else begin
			key_reg  <= key_next;
			en_reg   <= en_next;
			to_reg   <= to_next;
			load_reg <= load_next;
			cnt_reg  <= cnt_next;
		end
	end

	assign bus.en       = en_reg;
	assign bus.timeout  = to_reg;
	assign bus.load_val = load_reg;
	assign bus.count    = cnt_reg;

	wd_count_down_a: assert property (
		@(posedge clk) disable iff (!rstn)
		(tick && en_reg && cnt_reg != '0 && !bus.wr) |=> cnt_reg == $past(cnt_reg) - 1'b1)
		else $error("watchdog did not decrement on tick");
	wd_timeout_a: assert property (
		@(posedge clk) disable iff (!rstn)
		(tick && en_reg && cnt_reg == btw_wdcnt_t'(1) && !bus.wr) |=> to_reg ##1 to_reg || $past(bus.wr))
		else $error("timeout not raised at zero");
	wd_arm_a: assert property (
		@(posedge clk) disable iff (!rstn)
		(bus.wr && key_reg == BTW_KEY_IDLE && key == `BTW_KEY_ARM) |=> key_reg == BTW_KEY_ARMED)
		else $error("arming write did not arm");
	wd_apply_a: assert property (
		@(posedge clk) disable iff (!rstn)
		(bus.wr && key_reg == BTW_KEY_ARMED && key == `BTW_KEY_UPD)
			|=> en_reg == $past(bus.wdata[`BTW_WD_EN_BIT]) && !to_reg)
		else $error("armed update not applied");
	wd_bad_key_a: assert property (
		@(posedge clk) disable iff (!rstn)
		(bus.wr && !(key_reg == BTW_KEY_ARMED && key == `BTW_KEY_UPD))
			|=> key_reg != BTW_KEY_ARMED || $past(key) == `BTW_KEY_ARM
			##0 $stable(load_reg) && $stable(en_reg))
		else $error("unarmed or bad key changed the watchdog");
endmodule

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "btw_cfg.svh"

module testbench import btw_pkg::*;;
	localparam int WD1_US = 20;
	localparam int WD2_US = 30;
	localparam int CEIL   = 20000;

	logic        CLK;
	logic        RSTN;
	logic        HSEL;
	logic [31:0] HADDR;
	logic [1:0]  HTRANS;
	logic        HWRITE;
	logic [2:0]  HSIZE;
	logic [31:0] HWDATA;
	logic [31:0] HRDATA;
	logic        HREADYOUT;
	logic        HRESP;
	logic        BRD_RST_SRC;
	logic        IRQ;
	logic        INT_WDOG_REQ;
	logic        RST_WDOG_OUT;
	logic        HARD_RESET;
	logic [31:0] rd_smp;
	logic        rdy_smp;
	logic [31:0] rd;
	logic [31:0] rd2;
	logic [40:0] rows [11];
	int          n_errors;
	int          total_checks;
	int          cyc;
	int          t0;
	int          t1;

	btw_top #(
		.WD1_DEFAULT_US(btw_wdcnt_t'(WD1_US)),
		.WD2_DEFAULT_US(btw_wdcnt_t'(WD2_US))
	) dut (
		.CLK(CLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.BRD_RST_SRC(BRD_RST_SRC), .IRQ(IRQ), .INT_WDOG_REQ(INT_WDOG_REQ),
		.RST_WDOG_OUT(RST_WDOG_OUT), .HARD_RESET(HARD_RESET)
	);

	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	// values that stand through a cycle, as seen at its closing rising edge
	always @(negedge CLK) begin
		rd_smp = HRDATA;
		rdy_smp = HREADYOUT;
	end

	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == CEIL) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'b10;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		do begin @(posedge CLK); n++; end while (rdy_smp !== 1'b1 && n < 50);
		HSEL <= 1'b0;
		HTRANS <= 2'b00;
		HWDATA <= d;
		do begin @(posedge CLK); n++; end while (rdy_smp !== 1'b1 && n < 100);
		rd = rd_smp;
		if (n >= 50) chk(32'(n), 32'h2);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic wd_upd(input logic [7:0] a, input logic en, input logic rl, input logic [21:0] p);
		wr(a, 32'h55000000);
		wr(a, {8'haa, en, rl, p});
	endtask

	function automatic logic sig(input int w);
		case (w)
			0: return INT_WDOG_REQ;
			1: return RST_WDOG_OUT;
			2: return IRQ;
			default: return HARD_RESET;
		endcase
	endfunction

	// waits on falling edges so the level is settled; t1 stamps the hit
	task automatic wait_for(input int w, input logic v, input int lim);
		int n;
		n = 0;
		@(negedge CLK);
		while (sig(w) !== v && n < lim) begin
			@(negedge CLK);
			n++;
		end
		chk({31'h0, sig(w)}, {31'h0, v});
		t1 = cyc;
	endtask

	task automatic span(input int lo, input int hi);
		chk(32'((t1 - t0) >= lo && (t1 - t0) <= hi), 32'h1);
	endtask

	initial begin
		RSTN = 1'b0;
		HSEL = 1'b0;
		HADDR = 32'h0;
		HTRANS = 2'b00;
		HWRITE = 1'b0;
		HSIZE = 3'b010;
		HWDATA = 32'h0;
		BRD_RST_SRC = 1'b0;
		rows = '{
			{1'b0, 8'h30, 32'h00800014},
			{1'b0, 8'h34, 32'h0080001e},
			{1'b1, 8'h00, 32'hfffff5fa},
			{1'b0, 8'h00, 32'h0000050a},
			{1'b1, 8'h14, 32'hffffffff},
			{1'b0, 8'h14, 32'hffffffff},
			{1'b1, 8'h44, 32'hffffffff},
			{1'b0, 8'h44, 32'h0000003f},
			{1'b1, 8'h80, 32'h12345678},
			{1'b0, 8'h80, 32'h00000000},
			{1'b0, 8'h40, 32'h00000000}
		};
		repeat (6) @(posedge CLK);
		RSTN <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i][40]) begin
				wr(rows[i][39:32], rows[i][31:0]);
			end else begin
				rdc(rows[i][39:32], rows[i][31:0]);
			end
		end
		// reset again in mid-run: all state must return to defaults
		@(posedge CLK);
		RSTN <= 1'b0;
		repeat (5) @(posedge CLK);
		@(negedge CLK);
		chk({IRQ, INT_WDOG_REQ, RST_WDOG_OUT, HARD_RESET, HRESP, HREADYOUT}, 32'h1);
		@(posedge CLK);
		RSTN <= 1'b1;
		t0 = cyc;
		wait_for(0, 1'b1, 3000);
		span(WD1_US * 125 - 5, WD1_US * 125 + 15);
		chk({31'h0, RST_WDOG_OUT}, 32'h0);
		wait_for(1, 1'b1, 2000);
		span(WD2_US * 125 - 5, WD2_US * 125 + 15);
		// the bench stands in for board logic and does not act on the line, so the run goes on unreset
		wait_for(3, 1'b1, 3);
		rdc(8'h40, 32'h30);
		chk({31'h0, IRQ}, 32'h0);
		wr(8'h44, 32'h10);
		wait_for(2, 1'b1, 4);
		wr(8'h40, 32'h10);
		wait_for(2, 1'b0, 4);
		wr(8'h30, 32'haa800005);
		rdc(8'h30, 32'h00c00014);
		wr(8'h30, 32'h55000000);
		wr(8'h30, 32'h12800005);
		wr(8'h30, 32'haa800005);
		rdc(8'h30, 32'h00c00014);
		chk({31'h0, INT_WDOG_REQ}, 32'h1);
		wd_upd(8'h30, 1'b1, 1'b0, 22'h5);
		t0 = cyc;
		rdc(8'h30, 32'h00800005);
		// the microsecond divider runs free, so the first tick lands anywhere in 1..125 cycles
		wait_for(0, 1'b1, 700);
		span(495, 635);
		chk({31'h0, RST_WDOG_OUT}, 32'h1);
		wd_upd(8'h30, 1'b1, 1'b1, 22'h3);
		t0 = cyc;
		rdc(8'h30, 32'h00800005);
		wait_for(0, 1'b1, 700);
		span(495, 635);
		wd_upd(8'h30, 1'b0, 1'b0, 22'h0);
		rdc(8'h30, 32'h00000001);
		wd_upd(8'h34, 1'b0, 1'b0, 22'h3fffff);
		rdc(8'h34, 32'h003d0900);
		ahb(1'b0, 8'h38, 32'h0);
		rd2 = rd;
		repeat (300) @(posedge CLK);
		rdc(8'h38, rd2);
		wait_for(3, 1'b0, 4);
		chk({INT_WDOG_REQ, RST_WDOG_OUT}, 32'h0);
		@(posedge CLK);
		BRD_RST_SRC <= 1'b1;
		t0 = cyc;
		wait_for(3, 1'b1, 6);
		span(2, 4);
		@(posedge CLK);
		BRD_RST_SRC <= 1'b0;
		wait_for(3, 1'b0, 6);
		wr(8'h44, 32'h01);
		wr(8'h10, 32'd31);
		wr(8'h00, 32'h101);
		wait_for(2, 1'b1, 400);
		t0 = t1;
		wr(8'h40, 32'h01);
		wait_for(2, 1'b0, 4);
		wait_for(2, 1'b1, 400);
		chk(32'(t1 - t0), 32'd256);
		stop_test();
	end
endmodule

`default_nettype wire
